// file: rtl/asp_top.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
// How it works
// RULE_01: Full duplex serial, timer-derived bit clock.
// RULE_02: Data address: read receive, write transmit.
// RULE_03: Start, eight data bits, stop bit.
// RULE_04: Parity on: top bit sent odd parity.
// RULE_05: Parity on: received top bit flags error.
// RULE_06: Software handles even parity itself.
// RULE_07: Mode bit 6 routes pins to serial.
// RULE_08: Mode bit 7 enables odd parity.
// RULE_09: Bit rate clock/(8*prescale*count*16).
// RULE_10: That rate times every bit on line.
// RULE_11: Count and prescale in separate registers.
// RULE_12: Software sets prescale bits, continuous mode.
// RULE_13: Receive done request on buffer load.
// RULE_14: Transmit done request after stop bit.
// RULE_15: Timer control bits 0,1 load and start; here bit 0 starts and bit 1 loads.
// RULE_16: Software sets up interrupt controller first.
// RULE_17: Start on falling edge, mid-bit sampling.
// RULE_18: Request flags held until written zero.
// RULE_19: Output idles high, stop bit high.
module asp_top
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [asp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [asp_pkg::DATA_W-1:0] reg_rdata,
   input wire logic serial_in_line,
   input wire logic port_out_value,
   output logic serial_out_line,
   output logic rx_done_request,
   output logic tx_done_request,
   output logic tx_fifo_ready
);
   import asp_pkg::*;
   logic rst_meta_reg;
   logic rst_n;
   logic [7:0] cnt_reg;
   logic [7:0] pre_reg;
   logic [7:0] pmode_reg;
   logic [7:0] tmr_reg;
   logic [7:0] irq_reg;
   logic [7:0] rx_buf_reg;
   logic [7:0] rdata_reg;
   logic [2:0] div8_reg;
   logic [5:0] pre_live_reg;
   logic [7:0] cnt_live_reg;
   asp_state_t tx_state_reg;
   logic [3:0] tx_ovs_reg;
   logic [2:0] tx_bit_reg;
   logic [7:0] tx_shift_reg;
   logic tx_line_reg;
   logic tx_done_pulse;
   asp_state_t rx_state_reg;
   logic [3:0] rx_ovs_reg;
   logic [2:0] rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic rx_prev_reg;
   logic rx_done_pulse;
   logic serial_out_reg;
   asp_stream_if #(.WIDTH(DATA_W)) tx_wr ();
   asp_stream_if #(.WIDTH(DATA_W)) tx_rd ();
   // Reset release through two flops
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end
   // Address decode
   wire sel_data = (reg_addr == ADDR_DATA);
   wire sel_tmr = (reg_addr == ADDR_TMR);
   wire sel_cnt = (reg_addr == ADDR_CNT);
   wire sel_pre = (reg_addr == ADDR_PRE);
   wire sel_pmode = (reg_addr == ADDR_PMODE);
   wire sel_irq = (reg_addr == ADDR_IRQ);
   wire wr_tmr = reg_wr & sel_tmr;
   wire load_pulse = wr_tmr & reg_wdata[TMR_LOAD]; // RULE_15
   wire ser_en = pmode_reg[PM_SER_EN]; // RULE_07
   wire par_en = pmode_reg[PM_PAR_EN]; // RULE_08
   wire timer_run = tmr_reg[TMR_EN];
   wire serial_active = ser_en & timer_run; // RULE_01
   // Baud divider: fixed /8, then prescaler, then counter
   wire div8_wrap = timer_run & (div8_reg == FIXED_DIV_LAST); // RULE_09
   wire pre_wrap = div8_wrap & (pre_live_reg == PRE_LAST);
   wire tick16 = pre_wrap & (cnt_live_reg == CNT_LAST); // RULE_09
   wire single_pass_end = tick16 & ~pre_reg[PRE_CONT];
   // Writes to the data address feed the transmit FIFO
   assign tx_wr.valid = reg_wr & sel_data; // RULE_02
   assign tx_wr.data = reg_wdata;
   assign tx_fifo_ready = tx_wr.ready;
   asp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .wr(tx_wr.snk),
      .rd(tx_rd.src)
   );
   // Frames start on a tick so every bit spans sixteen ticks
   wire tx_idle = (tx_state_reg == ASP_IDLE);
   assign tx_rd.ready = tx_idle & serial_active & tick16; // RULE_10
   wire tx_par_bit = ~^tx_rd.data[6:0]; // RULE_04
   wire [7:0] tx_load = par_en ? {tx_par_bit, tx_rd.data[6:0]} : tx_rd.data; // RULE_04
   wire tx_bit_end = tick16 & (tx_ovs_reg == OVS_LAST);
   // Receive sampling terms; the stop bit is timed to its centre but its level is never sampled
   wire rx_fall = rx_prev_reg & ~serial_in_line; // RULE_17
   wire rx_mid = tick16 & (rx_ovs_reg == OVS_HALF); // RULE_17
   wire rx_err = ~^rx_shift_reg; // RULE_05
   wire [7:0] rx_byte = par_en ? {rx_err, rx_shift_reg[6:0]} : rx_shift_reg; // RULE_05
   // Interrupt request flags; hardware set beats software write
   wire [7:0] irq_set = ({7'h00, rx_done_pulse} << IRQ_RX) | ({7'h00, tx_done_pulse} << IRQ_TX);
   wire [7:0] irq_base = (reg_wr & sel_irq) ? reg_wdata : irq_reg; // RULE_18
   wire [7:0] irq_next = irq_base | irq_set; // RULE_18
   // Read mux; unmapped addresses read zero
   wire [7:0] rdata_next = sel_data ? rx_buf_reg : // RULE_02
      sel_tmr ? tmr_reg :
      sel_cnt ? cnt_reg :
      sel_pre ? pre_reg :
      sel_pmode ? pmode_reg :
      sel_irq ? irq_reg : RESET_BYTE;
   // Configuration registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= RESET_BYTE;
         pre_reg <= RESET_BYTE;
         pmode_reg <= RESET_BYTE;
      end
      else if (reg_wr)
      begin
         if (sel_cnt)
         begin
            cnt_reg <= reg_wdata; // RULE_11
         end
         if (sel_pre)
         begin
            pre_reg <= reg_wdata; // RULE_11
         end
         if (sel_pmode)
         begin
            pmode_reg <= reg_wdata;
         end
      end
   end
   // Timer control; single-pass mode stops itself after one period
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmr_reg <= RESET_BYTE;
      end
      else if (wr_tmr)
      begin
         tmr_reg <= reg_wdata & ~(8'h01 << TMR_LOAD); // RULE_15
      end
      else if (single_pass_end)
      begin
         tmr_reg[TMR_EN] <= 1'b0;
      end
   end
   // Live divider chain; prescale of 0 counts 64, count of 0 counts 256
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div8_reg <= '0;
         pre_live_reg <= '0;
         cnt_live_reg <= RESET_BYTE;
      end
      else if (load_pulse)
      begin
         div8_reg <= '0; // RULE_15
         pre_live_reg <= pre_reg[PRE_MSB:PRE_LSB];
         cnt_live_reg <= cnt_reg;
      end
      else if (timer_run)
      begin
         div8_reg <= div8_reg + 1'b1;
         if (pre_wrap)
         begin
            pre_live_reg <= pre_reg[PRE_MSB:PRE_LSB]; // RULE_09
            cnt_live_reg <= (cnt_live_reg == CNT_LAST) ? cnt_reg : cnt_live_reg - 1'b1;
         end
         else if (div8_wrap)
         begin
            pre_live_reg <= pre_live_reg - 1'b1;
         end
      end
   end
   // Transmitter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_state_reg <= ASP_IDLE;
         tx_ovs_reg <= '0;
         tx_bit_reg <= '0;
         tx_shift_reg <= RESET_BYTE;
         tx_line_reg <= 1'b1;
         tx_done_pulse <= 1'b0;
      end
      else
      begin
         tx_done_pulse <= 1'b0;
         if (tick16 && !tx_idle)
         begin
            tx_ovs_reg <= tx_ovs_reg + 1'b1;
         end
         case (tx_state_reg)
            ASP_IDLE:
            begin
               tx_line_reg <= 1'b1; // RULE_19
               if (tx_rd.ready && tx_rd.valid)
               begin
                  tx_shift_reg <= tx_load;
                  tx_ovs_reg <= '0;
                  tx_bit_reg <= '0;
                  tx_line_reg <= 1'b0; // RULE_03
                  tx_state_reg <= ASP_START;
               end
            end
            ASP_START:
            begin
               if (tx_bit_end)
               begin
                  tx_line_reg <= tx_shift_reg[0];
                  tx_state_reg <= ASP_DATA;
               end
            end
            ASP_DATA:
            begin
               if (tx_bit_end)
               begin
                  tx_bit_reg <= tx_bit_reg + 1'b1;
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  if (tx_bit_reg == BIT_LAST)
                  begin
                     tx_line_reg <= 1'b1; // RULE_19
                     tx_state_reg <= ASP_STOP;
                  end
                  else
                  begin
                     tx_line_reg <= tx_shift_reg[1]; // RULE_03
                  end
               end
            end
            ASP_STOP:
            begin
               if (tx_bit_end)
               begin
                  tx_done_pulse <= 1'b1; // RULE_14
                  tx_state_reg <= ASP_IDLE;
               end
            end
            default:
            begin
               tx_state_reg <= ASP_IDLE;
            end
         endcase
      end
   end
   // Receiver and its buffer; no framing check, a low stop bit still loads
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_buf_reg <= RESET_BYTE;
         rx_state_reg <= ASP_IDLE;
         rx_ovs_reg <= '0;
         rx_bit_reg <= '0;
         rx_shift_reg <= RESET_BYTE;
         rx_prev_reg <= 1'b1;
         rx_done_pulse <= 1'b0;
      end
      else
      begin
         rx_prev_reg <= serial_in_line;
         rx_done_pulse <= 1'b0;
         if (tick16)
         begin
            rx_ovs_reg <= rx_ovs_reg + 1'b1;
         end
         case (rx_state_reg)
            ASP_IDLE:
            begin
               if (serial_active && rx_fall)
               begin
                  rx_ovs_reg <= '0; // RULE_17
                  rx_bit_reg <= '0;
                  rx_state_reg <= ASP_START;
               end
            end
            ASP_START:
            begin
               if (rx_mid)
               begin
                  // Re-centre the tick phase on mid bit
                  rx_ovs_reg <= OVS_HALF + 1'b1;
                  rx_state_reg <= serial_in_line ? ASP_IDLE : ASP_DATA; // RULE_17
               end
            end
            ASP_DATA:
            begin
               if (rx_mid)
               begin
                  rx_shift_reg <= {serial_in_line, rx_shift_reg[7:1]}; // RULE_03
                  rx_bit_reg <= rx_bit_reg + 1'b1;
                  if (rx_bit_reg == BIT_LAST)
                  begin
                     rx_state_reg <= ASP_STOP;
                  end
               end
            end
            ASP_STOP:
            begin
               if (rx_mid)
               begin
                  rx_done_pulse <= 1'b1; // RULE_13
                  rx_buf_reg <= rx_byte; // RULE_05
                  rx_state_reg <= ASP_IDLE;
               end
            end
            default:
            begin
               rx_state_reg <= ASP_IDLE;
            end
         endcase
         if (!serial_active)
         begin
            rx_state_reg <= ASP_IDLE;
         end
      end
   end
   // Request flags, read data and pin mux
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_reg <= RESET_BYTE;
         rdata_reg <= RESET_BYTE;
         serial_out_reg <= 1'b1;
      end
      else
      begin
         irq_reg <= irq_next; // RULE_18
         rdata_reg <= reg_rd ? rdata_next : RESET_BYTE;
         serial_out_reg <= ser_en ? tx_line_reg : port_out_value; // RULE_07
      end
   end
   // Outputs straight from flops
   assign reg_rdata = rdata_reg;
   assign serial_out_line = serial_out_reg;
   assign rx_done_request = irq_reg[IRQ_RX]; // RULE_13
   assign tx_done_request = irq_reg[IRQ_TX]; // RULE_14
endmodule : asp_top

// file: rtl/asp_pkg.sv
package asp_pkg;
   // Register map, byte addresses on the 8-bit register port
   localparam logic [7:0] ADDR_DATA = 8'hF0;
   localparam logic [7:0] ADDR_TMR = 8'hF1;
   localparam logic [7:0] ADDR_CNT = 8'hF4;
   localparam logic [7:0] ADDR_PRE = 8'hF5;
   localparam logic [7:0] ADDR_PMODE = 8'hF7;
   localparam logic [7:0] ADDR_IRQ = 8'hFA;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Field positions
   localparam int PM_SER_EN = 6;
   localparam int PM_PAR_EN = 7;
   localparam int TMR_EN = 0;
   localparam int TMR_LOAD = 1;
   localparam int PRE_CONT = 0;
   localparam int PRE_LSB = 2;
   localparam int PRE_MSB = 7;
   localparam int IRQ_RX = 3;
   localparam int IRQ_TX = 4;
   // Divider and framing counts
   localparam logic [2:0] FIXED_DIV_LAST = 3'h7;
   localparam logic [5:0] PRE_LAST = 6'h01;
   localparam logic [7:0] CNT_LAST = 8'h01;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_HALF = 4'h7;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 4;
   typedef enum logic [1:0] {
      ASP_IDLE = 2'b00,
      ASP_START = 2'b01,
      ASP_DATA = 2'b10,
      ASP_STOP = 2'b11
   } asp_state_t;
endpackage : asp_pkg

// file: rtl/asp_stream_if.sv
`timescale 1ns/1ns
interface asp_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : asp_stream_if

// file: rtl/asp_fifo.sv
`timescale 1ns/1ns
module asp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   asp_stream_if.snk wr,
   asp_stream_if.src rd
);
   // Pointers wrap by overflow, so DEPTH must be a power of two
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] count_reg;
   wire push = wr.valid & wr.ready;
   wire pop = rd.valid & rd.ready;

   // Honest flags straight from the fill count
   assign wr.ready = (count_reg != FULL_CNT);
   assign rd.valid = (count_reg != '0);
   assign rd.data = mem[rptr_reg];

   // Storage has no reset, only pointers and count do
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wptr_reg] <= wr.data;
      end
   end

   // Pointer and count bookkeeping
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop)
         begin
            rptr_reg <= rptr_reg + 1'b1;
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule : asp_fifo

// file: testbench/asp_checker.sv
`timescale 1ns/1ns
module asp_checker
   import asp_pkg::*;
#(
   parameter int BIT_CLKS = 128
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [asp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [asp_pkg::DATA_W-1:0] reg_rdata,
   input wire logic serial_in_line,
   input wire logic port_out_value,
   input wire logic serial_out_line,
   input wire logic rx_done_request,
   input wire logic tx_done_request,
   input wire logic tx_fifo_ready
);
   logic ser_mode_reg;
   logic [10:0] lo_cnt_reg;
   logic [7:0] hi_cnt_reg;
   logic [7:0] in_hi_reg;
   logic wr_irq;
   logic wr_data;
   logic mapped;
   // Strobe decodes seen from the port
   assign wr_irq = reg_wr && reg_addr == ADDR_IRQ;
   assign wr_data = reg_wr && reg_addr == ADDR_DATA;
   assign mapped = reg_addr inside {ADDR_DATA, ADDR_TMR, ADDR_CNT, ADDR_PRE, ADDR_PMODE, ADDR_IRQ};
   // Mirror of serial enable; high run lengths saturate so idle never wraps
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ser_mode_reg <= 1'b0;
         lo_cnt_reg <= 11'h000;
         hi_cnt_reg <= 8'h00;
         in_hi_reg <= 8'h00;
      end
      else
      begin
         if (reg_wr && reg_addr == ADDR_PMODE)
            ser_mode_reg <= reg_wdata[PM_SER_EN];
         lo_cnt_reg <= serial_out_line ? 11'h000 : lo_cnt_reg + 11'h001;
         hi_cnt_reg <= serial_out_line ? hi_cnt_reg + {7'h00, ~&hi_cnt_reg} : 8'h00;
         in_hi_reg <= serial_in_line ? in_hi_reg + {7'h00, ~&in_hi_reg} : 8'h00;
      end
   end
   default clocking ck @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_unmapped_zero;
      reg_rd && !mapped |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   property p_flags_hold;
      !wr_irq |=> rx_done_request >= $past(rx_done_request) && tx_done_request >= $past(tx_done_request);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("request flag fell without write");
   property p_flag_read;
      reg_rd && reg_addr == ADDR_IRQ |=> reg_rdata[IRQ_RX] == $past(rx_done_request)
         && reg_rdata[IRQ_TX] == $past(tx_done_request);
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag read mismatch");
   property p_load_reads_zero;
      reg_rd && reg_addr == ADDR_TMR |=> !reg_rdata[TMR_LOAD];
   endproperty
   a_load_reads_zero: assert property (p_load_reads_zero) else $error("load bit read back set");
   property p_port_mode;
      !ser_mode_reg && !(reg_wr && reg_addr == ADDR_PMODE) |=> serial_out_line == $past(port_out_value);
   endproperty
   a_port_mode: assert property (p_port_mode) else $error("port value not on pin");
   property p_stop_high;
      $rose(tx_done_request) |-> serial_out_line && hi_cnt_reg >= 8'h78;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit short or low");
   property p_low_run;
      $rose(serial_out_line) && ser_mode_reg |-> lo_cnt_reg % BIT_CLKS == 0;
   endproperty
   a_low_run: assert property (p_low_run) else $error("low run not whole bits");
   property p_fifo_fall;
      $fell(tx_fifo_ready) |-> $past(wr_data);
   endproperty
   a_fifo_fall: assert property (p_fifo_fall) else $error("fifo full without write");
   property p_rx_mid_stop;
      $rose(rx_done_request) |-> in_hi_reg >= 8'h30;
   endproperty
   a_rx_mid_stop: assert property (p_rx_mid_stop) else $error("receive done before mid stop");
endmodule : asp_checker

bind asp_top asp_checker chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_line(serial_in_line),
   .port_out_value(port_out_value), .serial_out_line(serial_out_line), .rx_done_request(rx_done_request),
   .tx_done_request(tx_done_request), .tx_fifo_ready(tx_fifo_ready));

// file: testbench/asp_remote.sv
`timescale 1ns/1ns
module asp_remote #(
   parameter int BIT = 128
) (
   input wire logic clk,
   input wire logic from_dut,
   output logic to_dut
);
   logic [7:0] got[$];
   logic [7:0] sh;
   initial to_dut = 1'b1;
   // Sender: start low, eight bits LSB first, stop high, then idle
   task automatic send(input logic [7:0] b);
      to_dut <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         to_dut <= b[i];
         repeat (BIT) @(posedge clk);
      end
      to_dut <= 1'b1;
      repeat (BIT * 2) @(posedge clk);
   endtask : send
   // Receiver samples mid-bit; a bad stop drops the frame
   always
   begin
      @(negedge from_dut);
      repeat (BIT / 2) @(posedge clk);
      if (from_dut === 1'b0)
      begin
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT) @(posedge clk);
            sh[i] = from_dut;
         end
         repeat (BIT) @(posedge clk);
         if (from_dut === 1'b1)
            got.push_back(sh);
      end
   end
endmodule : asp_remote

// file: testbench/async_serial_port_bench.sv
`timescale 1ns/1ns
module async_serial_port_bench;
   import asp_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic port_out_value = 1'b1;
   logic [7:0] reg_rdata;
   logic serial_in_line;
   logic serial_out_line;
   logic rx_done_request;
   logic tx_done_request;
   logic tx_fifo_ready;
   int err_count = 0;
   int comparisons = 0;
   int n;
   logic [7:0] map_a[7] = '{ADDR_DATA, ADDR_TMR, ADDR_CNT, ADDR_PRE, ADDR_PMODE, ADDR_IRQ, 8'h10};
   logic [7:0] rx_in[4] = '{8'h43, 8'h47, 8'hF8, 8'h78};
   logic [7:0] rx_out[4] = '{8'h43, 8'hC7, 8'h78, 8'hF8};
   logic [7:0] tx_in[4] = '{8'hC3, 8'h78, 8'hC3, 8'h78};
   logic [7:0] tx_out[4] = '{8'h43, 8'hF8, 8'h43, 8'hF8};
   always #5 clk = ~clk;
   asp_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_line(serial_in_line), .port_out_value(port_out_value),
      .serial_out_line(serial_out_line), .rx_done_request(rx_done_request), .tx_done_request(tx_done_request),
      .tx_fifo_ready(tx_fifo_ready));
   asp_remote #(.BIT(128)) far (.clk(clk), .from_dut(serial_out_line), .to_dut(serial_in_line));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Strobes drop before the next edge so calls may follow directly
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      check($sformatf("reg %h", a), reg_rdata, exp);
   endtask : rchk
   task automatic wait_got(input int k);
      for (int i = 0; i < 9000 && far.got.size() < k; i++)
         @(posedge clk);
      check("frames by limit", 8'(far.got.size()), 8'(k));
   endtask : wait_got
   task automatic give_verdict();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   // Watchdog well beyond the roughly 14000 cycles the tests need
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      give_verdict();
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (map_a[i]) rchk(map_a[i], RESET_BYTE);
      check("idle line", {7'h00, serial_out_line}, 8'h01);
      port_out_value <= 1'b0;
      repeat (3) @(posedge clk);
      check("port pin", {7'h00, serial_out_line}, 8'h00);
      port_out_value <= 1'b1;
      repeat (2) @(posedge clk); // Pin rises while still in port mode
      wr(ADDR_PMODE, 8'h40);
      wr(ADDR_CNT, 8'h01);
      wr(ADDR_PRE, 8'h05);
      port_out_value <= 1'b0;
      n = 0;
      while (tx_fifo_ready === 1'b1 && n < 8)
      begin
         wr(ADDR_DATA, 8'h10 + 8'(n));
         n++;
      end
      check("fifo fill", 8'(n), 8'(FIFO_DEPTH));
      check("fifo full", {7'h00, tx_fifo_ready}, 8'h00);
      wr(ADDR_DATA, 8'hEE);
      wr(ADDR_TMR, 8'h03);
      rchk(ADDR_CNT, 8'h01);
      rchk(ADDR_PRE, 8'h05);
      rchk(ADDR_TMR, 8'h01);
      wait_got(n);
      repeat (1500) @(posedge clk);
      check("frames", 8'(far.got.size()), 8'(n));
      for (int i = 0; i < n; i++) check("tx byte", far.got[i], 8'h10 + 8'(i));
      check("idle serial", {7'h00, serial_out_line}, 8'h01);
      check("tx flag", {7'h00, tx_done_request}, 8'h01);
      rchk(ADDR_IRQ, 8'h10);
      wr(ADDR_IRQ, 8'h00);
      rchk(ADDR_IRQ, 8'h00);
      far.send(8'h3C);
      rchk(ADDR_IRQ, 8'h08);
      rchk(ADDR_DATA, 8'h3C);
      wr(ADDR_PMODE, 8'hC0);
      // Transmit and receive overlap in each pass
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_IRQ, 8'h00);
         wr(ADDR_DATA, tx_in[i]);
         far.send(rx_in[i]);
         check("rx flag", {7'h00, rx_done_request}, 8'h01);
         rchk(ADDR_DATA, rx_out[i]);
      end
      wait_got(n + 4);
      for (int i = 0; i < 4; i++) check("parity tx", far.got[n + i], tx_out[i]);
      give_verdict();
   end
endmodule : async_serial_port_bench
